// ---- verilog/fcd_decoder.sv ----
// Purpose: Command decoder and read mode selector of a multi-partition flash
// Assumes: Host strobes already on I_CLOCK; array and write engine outside
// Notes:   Four partitions (A[19:18]), 32 blocks (A[19:15]), offset on A[7:0]
`include "fcd_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - FFh to a partition selects array reads there.
// - After reset every partition reads array.
// - Array mode persists; no rewrite needed before reads.
// - Array read of a busy, unsuspended partition returns invalid data.
// - While suspended, FFh still switches the addressed partition to array.
// - 90h selects identifier mode for the partition.
// - Identifier or query command changes only read mode, never the job.
// - 98h selects query mode; query bytes on low eight lines only.
// - 70h selects status reads for the partition.
// - Clear, suspend and resume accepted at any address.
// - Erase is 20h then D0h; confirm address selects block.
// - Program is 40h or 10h, then the data word.
// - Fast factory program is 30h, D0h, then data writes.
// - C0h then data programs protection words, even after FFFDh at 80h sets the lock word.
// - 60h then 03h loads configuration from A[15:0].
// - Reads between setup and confirm keep the sequence.
// - Setup write puts the addressed partition into status mode.
// - Other partitions keep array reads during a pending sequence.
// - A wrong second write records a command sequence error.
// - Identifier offsets 00h, 01h and 05h: maker, part, configuration.
// - Offset 02h gives block lock on bit 0, lock-down on bit 1.
// - Protection words at 81h..88h, lock word at 80h.
// - After 60h: 01h locks, D0h unlocks unless down, 2Fh locks down.
// - Sequence error sets ready, erase-error and program-error bits.
// - Status reads drive zeros on the upper eight lines.
module fcd_decoder (
  input  wire logic                   I_CLOCK,
  input  wire logic                   I_SRST,
  input  wire logic                   I_WE,
  input  wire logic                   I_RE,
  input  wire logic [`FCD_AW-1:0]     I_ADDR,
  input  wire logic [15:0]            I_WDATA,
  input  wire logic [15:0]            I_ARRAY_DATA,
  input  wire logic [7:0]             I_QUERY_DATA,
  input  wire logic                   I_WSM_BUSY,
  input  wire logic [1:0]             I_WSM_PART,
  input  wire logic                   I_WSM_SUSPENDED,
  input  wire logic                   I_WSM_ERASE_ERR,
  input  wire logic                   I_WSM_PROG_ERR,
  input  wire logic                   I_EFP_DONE,
  input  wire logic                   I_SR_ESS,
  input  wire logic                   I_SR_VPPS,
  input  wire logic                   I_SR_PSS,
  input  wire logic                   I_SR_DPS,
  output logic [15:0]                 O_RDATA,
  output logic                        O_RVALID,
  output logic                        O_OP_START,
  output fcd_pkg::fcd_op_type         O_OP_KIND,
  output logic [`FCD_AW-1:0]          O_OP_ADDR,
  output logic [15:0]                 O_OP_DATA,
  output logic                        O_SUSPEND,
  output logic                        O_RESUME
);
  import fcd_pkg::*;

  // ---------------------------------------------
  // Address helpers
  // ---------------------------------------------
  function automatic logic [1:0] part_of(input logic [`FCD_AW-1:0] a);
    part_of = a[19:18];
  endfunction

  function automatic logic [4:0] blk_of(input logic [`FCD_AW-1:0] a);
    blk_of = a[19:15];
  endfunction

  function automatic logic [2:0] otp_index(input logic [7:0] off);
    logic [7:0] d;
    d = off - `FCD_ID_OTP_FIRST;
    otp_index = d[2:0];
  endfunction

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  fcd_mode_type mode [`FCD_NPART];
  fcd_seq_type  seq;
  logic [1:0]   lock_bits [`FCD_NBLK];
  logic [15:0]  otp_word [`FCD_NOTP];
  logic [15:0]  otp_lock;
  logic [15:0]  cfg_word;
  logic         err_es;
  logic         err_ps;

  // ---------------------------------------------
  // Decode of the incoming write and read
  // ---------------------------------------------
  logic [7:0]  w_cmd;
  logic [1:0]  w_wpart;
  logic [4:0]  w_wblk;
  logic [7:0]  w_woff;
  logic [1:0]  w_rpart;
  logic [4:0]  w_rblk;
  logic [7:0]  w_roff;
  logic        w_otp_whit;
  logic        w_otp_rhit;
  logic        w_part_busy;
  logic [7:0]  w_sr;
  logic [15:0] w_id_value;
  logic [15:0] w_rdata;
  fcd_mode_type w_rmode;

  assign w_cmd      = I_WDATA[7:0];
  assign w_wpart    = part_of(I_ADDR);
  assign w_wblk     = blk_of(I_ADDR);
  assign w_woff     = I_ADDR[7:0];
  assign w_rpart    = part_of(I_ADDR);
  assign w_rblk     = blk_of(I_ADDR);
  assign w_roff     = I_ADDR[7:0];
  assign w_rmode    = mode[w_rpart];
  assign w_otp_whit = (w_woff >= `FCD_ID_OTP_FIRST) && (w_woff <= `FCD_ID_OTP_LAST);
  assign w_otp_rhit = (w_roff >= `FCD_ID_OTP_FIRST) && (w_roff <= `FCD_ID_OTP_LAST);

  // Running job in the read partition; a suspended job lets the array through
  assign w_part_busy = I_WSM_BUSY && !I_WSM_SUSPENDED && (I_WSM_PART == w_rpart);

  // Status byte; ready also shows a sequence error even while busy
  assign w_sr = {(!I_WSM_BUSY) | (err_es & err_ps), I_SR_ESS, err_es, err_ps,
                 I_SR_VPPS, I_SR_PSS, I_SR_DPS,
                 I_WSM_BUSY && (I_WSM_PART != w_rpart)};

  // Identifier space; decoded on A[7:0] only, upper offset bits ignored
  assign w_id_value = (w_roff == `FCD_ID_MAKER)    ? `FCD_MAKER_CODE :
                      (w_roff == `FCD_ID_PART)     ? `FCD_PART_CODE :
                      (w_roff == `FCD_ID_LOCK)     ? {14'h0000, lock_bits[w_rblk]} :
                      (w_roff == `FCD_ID_CFG)      ? cfg_word :
                      (w_roff == `FCD_ID_OTP_LOCK) ? otp_lock :
                      w_otp_rhit                   ? otp_word[otp_index(w_roff)] :
                      16'h0000;

  // Read answer by partition mode
  assign w_rdata = (w_rmode == FCD_ARRAY) ? (w_part_busy ? `FCD_INVALID : I_ARRAY_DATA) :
                   (w_rmode == FCD_IDENT) ? w_id_value :
                   (w_rmode == FCD_QUERY) ? {8'h00, I_QUERY_DATA} :
                   {8'h00, w_sr};

  // ---------------------------------------------
  // Command sequencer
  // ---------------------------------------------
  fcd_seq_type  next_seq;
  fcd_mode_type mode_val;
  fcd_op_type   op_kind;
  logic         mode_wr;
  logic         seq_err;
  logic         op_go;
  logic         lock_wr;
  logic [1:0]   lock_val;
  logic         cfg_wr;
  logic         otp_wr;
  logic         otpl_wr;
  logic         clr;
  logic         susp;
  logic         resm;

  // Writes taken one per cycle; reads never touch this path
  always_comb begin
    next_seq = seq;
    mode_wr  = 1'b0;
    mode_val = mode[w_wpart];
    seq_err  = 1'b0;
    op_go    = 1'b0;
    op_kind  = FCD_OP_NONE;
    lock_wr  = 1'b0;
    lock_val = lock_bits[w_wblk];
    cfg_wr   = 1'b0;
    otp_wr   = 1'b0;
    otpl_wr  = 1'b0;
    clr      = 1'b0;
    susp     = 1'b0;
    resm     = 1'b0;
    if (seq == FCD_EFP_RUN && I_EFP_DONE) begin
      next_seq = FCD_IDLE;
    end else if (I_WE) begin
      case (seq)
        FCD_IDLE: begin
          case (w_cmd)
            `FCD_CMD_ARRAY: begin
              mode_wr  = 1'b1;
              mode_val = FCD_ARRAY;
            end
            `FCD_CMD_IDENT: begin
              mode_wr  = 1'b1;
              mode_val = FCD_IDENT;
            end
            `FCD_CMD_QUERY: begin
              mode_wr  = 1'b1;
              mode_val = FCD_QUERY;
            end
            `FCD_CMD_STATUS: begin
              mode_wr  = 1'b1;
              mode_val = FCD_STATUS;
            end
            `FCD_CMD_CLEAR:   clr  = 1'b1;
            `FCD_CMD_SUSPEND: susp = 1'b1;
            `FCD_CMD_CONFIRM: resm = 1'b1;
            `FCD_CMD_ERASE, `FCD_CMD_PROG, `FCD_CMD_PROG_ALT,
            `FCD_CMD_EFP, `FCD_CMD_OTP, `FCD_CMD_LOCKCFG: begin
              mode_wr  = 1'b1;
              mode_val = FCD_STATUS;
              next_seq = (w_cmd == `FCD_CMD_ERASE)   ? FCD_SQ_ERASE :
                         (w_cmd == `FCD_CMD_EFP)     ? FCD_SQ_EFP :
                         (w_cmd == `FCD_CMD_OTP)     ? FCD_SQ_OTP :
                         (w_cmd == `FCD_CMD_LOCKCFG) ? FCD_SQ_LCFG :
                         FCD_SQ_PROG;
            end
            default: ;
          endcase
        end
        FCD_SQ_ERASE: begin
          next_seq = FCD_IDLE;
          if (w_cmd == `FCD_CMD_CONFIRM) begin
            op_go   = 1'b1;
            op_kind = FCD_OP_ERASE;
          end else begin
            seq_err = 1'b1;
          end
        end
        FCD_SQ_PROG: begin
          next_seq = FCD_IDLE;
          op_go    = 1'b1;
          op_kind  = FCD_OP_PROG;
        end
        FCD_SQ_EFP: begin
          if (w_cmd == `FCD_CMD_CONFIRM) begin
            next_seq = FCD_EFP_RUN;
            op_go    = 1'b1;
            op_kind  = FCD_OP_EFP;
          end else begin
            next_seq = FCD_IDLE;
            seq_err  = 1'b1;
          end
        end
        FCD_EFP_RUN: begin
          op_go   = 1'b1;
          op_kind = FCD_OP_EDATA;
        end
        FCD_SQ_OTP: begin
          next_seq = FCD_IDLE;
          op_go    = 1'b1;
          op_kind  = FCD_OP_OTP;
          otpl_wr  = (w_woff == `FCD_ID_OTP_LOCK) && (I_WDATA == `FCD_OTP_LOCK_VAL);
          otp_wr   = w_otp_whit;
        end
        FCD_SQ_LCFG: begin
          next_seq = FCD_IDLE;
          case (w_cmd)
            `FCD_CMD_LOCK: begin
              lock_wr  = 1'b1;
              lock_val = {lock_bits[w_wblk][1], 1'b1};
            end
            `FCD_CMD_CONFIRM: begin
              lock_wr  = !lock_bits[w_wblk][1];
              lock_val = 2'b00;
            end
            `FCD_CMD_LOCKDOWN: begin
              lock_wr  = 1'b1;
              lock_val = 2'b11;
            end
            `FCD_CMD_SETCFG: begin
              cfg_wr   = 1'b1;
              mode_wr  = 1'b1;
              mode_val = FCD_ARRAY;
            end
            default: seq_err = 1'b1;
          endcase
        end
        default: next_seq = FCD_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  // Sequence and partition modes; every partition starts in array mode
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      seq <= FCD_IDLE;
      for (int i = 0; i < `FCD_NPART; i++) begin
        mode[i] <= FCD_ARRAY;
      end
    end else begin
      seq <= next_seq;
      if (mode_wr) begin
        mode[w_wpart] <= mode_val;
      end
    end
  end

  // Error flags: a new error beats a clear in the same cycle
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      err_es <= 1'b0;
      err_ps <= 1'b0;
    end else begin
      err_es <= seq_err | I_WSM_ERASE_ERR | (err_es & ~clr);
      err_ps <= seq_err | I_WSM_PROG_ERR | (err_ps & ~clr);
    end
  end

  // Block locks, configuration and protection words
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      cfg_word <= `FCD_CFG_RESET;
      otp_lock <= `FCD_OTPL_RESET;
      for (int i = 0; i < `FCD_NBLK; i++) begin
        lock_bits[i] <= `FCD_LOCK_RESET;
      end
      for (int i = 0; i < `FCD_NOTP; i++) begin
        otp_word[i] <= `FCD_OTP_RESET;
      end
    end else begin
      if (lock_wr) lock_bits[w_wblk] <= lock_val;
      if (cfg_wr) cfg_word <= I_ADDR[15:0];
      // Flash cells only clear bits, so programming ANDs in the data
      if (otpl_wr) otp_lock <= otp_lock & I_WDATA;
      if (otp_wr) otp_word[otp_index(w_woff)] <= otp_word[otp_index(w_woff)] & I_WDATA;
    end
  end

  // Outputs, all registered
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_RDATA    <= 16'h0000;
      O_RVALID   <= 1'b0;
      O_OP_START <= 1'b0;
      O_OP_KIND  <= FCD_OP_NONE;
      O_OP_ADDR  <= '0;
      O_OP_DATA  <= 16'h0000;
      O_SUSPEND  <= 1'b0;
      O_RESUME   <= 1'b0;
    end else begin
      O_RVALID   <= I_RE;
      O_OP_START <= op_go;
      O_SUSPEND  <= susp;
      O_RESUME   <= resm;
      if (I_RE) O_RDATA <= w_rdata;
      if (op_go) begin
        O_OP_KIND <= op_kind;
        O_OP_ADDR <= I_ADDR;
        O_OP_DATA <= I_WDATA;
      end
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);

  logic w_idle_wr;
  logic w_cmd_known;
  assign w_idle_wr = I_WE && (seq == FCD_IDLE);
  // Every code that the idle decoder acts on; anything else must be a no-op
  assign w_cmd_known = (w_cmd == `FCD_CMD_ARRAY) || (w_cmd == `FCD_CMD_IDENT) || (w_cmd == `FCD_CMD_QUERY) ||
                       (w_cmd == `FCD_CMD_STATUS) || (w_cmd == `FCD_CMD_CLEAR) || (w_cmd == `FCD_CMD_SUSPEND) ||
                       (w_cmd == `FCD_CMD_CONFIRM) || (w_cmd == `FCD_CMD_ERASE) || (w_cmd == `FCD_CMD_PROG) ||
                       (w_cmd == `FCD_CMD_PROG_ALT) || (w_cmd == `FCD_CMD_EFP) || (w_cmd == `FCD_CMD_OTP) ||
                       (w_cmd == `FCD_CMD_LOCKCFG);

  sequence s_setup_wr;
    w_idle_wr && (w_cmd == `FCD_CMD_ERASE);
  endsequence
  sequence s_status_rd;
    I_RE && !I_WE && (w_rmode == FCD_STATUS);
  endsequence

  property p_array_cmd;
    (w_idle_wr && w_cmd == `FCD_CMD_ARRAY) |=> (mode[$past(w_wpart)] == FCD_ARRAY);
  endproperty
  a_array_cmd: assert property (p_array_cmd) else $error("array command ignored");

  property p_reset_array;
    $past(I_SRST) |-> (mode[0] == FCD_ARRAY) && (mode[3] == FCD_ARRAY) && (seq == FCD_IDLE);
  endproperty
  a_reset_array: assert property (p_reset_array) else $error("mode not array after reset");

  property p_ident_cmd;
    (w_idle_wr && w_cmd == `FCD_CMD_IDENT) |=> (mode[$past(w_wpart)] == FCD_IDENT) && !O_OP_START;
  endproperty
  a_ident_cmd: assert property (p_ident_cmd) else $error("identifier command wrong");

  property p_query_rd;
    (I_RE && w_rmode == FCD_QUERY) |=> O_RVALID && (O_RDATA == {8'h00, $past(I_QUERY_DATA)});
  endproperty
  a_query_rd: assert property (p_query_rd) else $error("query read wrong");

  property p_status_rd;
    s_status_rd |=> O_RVALID && (O_RDATA[15:8] == 8'h00);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status upper byte not zero");

  property p_seq_err;
    seq_err |=> err_es && err_ps && w_sr[7] && (seq == FCD_IDLE);
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("sequence error not flagged");

  property p_setup_status;
    s_setup_wr |=> (seq == FCD_SQ_ERASE) && (mode[$past(w_wpart)] == FCD_STATUS);
  endproperty
  a_setup_status: assert property (p_setup_status) else $error("setup did not select status");

  property p_read_keeps;
    (I_RE && !I_WE && seq != FCD_IDLE && seq != FCD_EFP_RUN) |=> (seq == $past(seq));
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read broke a sequence");

  property p_busy_invalid;
    (I_RE && w_rmode == FCD_ARRAY && w_part_busy) |=> (O_RDATA == `FCD_INVALID);
  endproperty
  a_busy_invalid: assert property (p_busy_invalid) else $error("busy array read not invalid");

  property p_cfg_load;
    (I_WE && seq == FCD_SQ_LCFG && w_cmd == `FCD_CMD_SETCFG) |=> (cfg_word == $past(I_ADDR[15:0]));
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("configuration not loaded");

  property p_suspend;
    (w_idle_wr && w_cmd == `FCD_CMD_SUSPEND) |=> O_SUSPEND ##1 !O_SUSPEND;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend pulse wrong");

  property p_erase_go;
    (I_WE && seq == FCD_SQ_ERASE && w_cmd == `FCD_CMD_CONFIRM)
      |=> O_OP_START && (O_OP_KIND == FCD_OP_ERASE) && (O_OP_ADDR == $past(I_ADDR));
  endproperty
  a_erase_go: assert property (p_erase_go) else $error("erase not started");

  property p_unassigned;
    (w_idle_wr && !w_cmd_known) |=> (seq == FCD_IDLE) && $stable(err_es) && !O_OP_START &&
      (mode[$past(w_wpart)] == $past(mode[w_wpart]));
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned code had effect");

endmodule
`default_nettype wire

// ---- shared/fcd_map.svh ----
// Purpose: Constants of the flash command decoder
// Assumes: 16-bit data bus, 20-bit word address
// Notes:   Definitions only
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
// ---------------------------------------------
// Command codes
// ---------------------------------------------
`define FCD_CMD_ARRAY    8'hff
`define FCD_CMD_IDENT    8'h90
`define FCD_CMD_QUERY    8'h98
`define FCD_CMD_STATUS   8'h70
`define FCD_CMD_CLEAR    8'h50
`define FCD_CMD_SUSPEND  8'hb0
`define FCD_CMD_CONFIRM  8'hd0
`define FCD_CMD_ERASE    8'h20
`define FCD_CMD_PROG     8'h40
`define FCD_CMD_PROG_ALT 8'h10
`define FCD_CMD_EFP      8'h30
`define FCD_CMD_OTP      8'hc0
`define FCD_CMD_LOCKCFG  8'h60
`define FCD_CMD_LOCK     8'h01
`define FCD_CMD_LOCKDOWN 8'h2f
`define FCD_CMD_SETCFG   8'h03
`define FCD_OTP_LOCK_VAL 16'hfffd
// ---------------------------------------------
// Identifier offsets and address fields
// ---------------------------------------------
`define FCD_ID_MAKER     8'h00
`define FCD_ID_PART      8'h01
`define FCD_ID_LOCK      8'h02
`define FCD_ID_CFG       8'h05
`define FCD_ID_OTP_LOCK  8'h80
`define FCD_ID_OTP_FIRST 8'h81
`define FCD_ID_OTP_LAST  8'h88
`define FCD_AW           20
`define FCD_NPART        4
`define FCD_NBLK         32
`define FCD_NOTP         8
// ---------------------------------------------
// Reset values and fixed answers
// ---------------------------------------------
`define FCD_CFG_RESET    16'h0000
`define FCD_LOCK_RESET   2'b01
`define FCD_OTPL_RESET   16'hffff
`define FCD_OTP_RESET    16'hffff
`define FCD_INVALID      16'hffff
`define FCD_MAKER_CODE   16'h00a5
`define FCD_PART_CODE    16'h005a
`endif

// ---- shared/fcd_pkg.sv ----
// Purpose: Types of the flash command decoder
// Assumes: Constants come from fcd_map.svh
// Notes:   Types only
package fcd_pkg;
  // Read output mode of one partition
  typedef enum logic [1:0] {
    FCD_ARRAY  = 2'b00,
    FCD_IDENT  = 2'b01,
    FCD_QUERY  = 2'b10,
    FCD_STATUS = 2'b11
  } fcd_mode_type;
  // Pending write sequence
  typedef enum logic [2:0] {
    FCD_IDLE     = 3'b000,
    FCD_SQ_ERASE = 3'b001,
    FCD_SQ_PROG  = 3'b010,
    FCD_SQ_EFP   = 3'b011,
    FCD_SQ_OTP   = 3'b100,
    FCD_SQ_LCFG  = 3'b101,
    FCD_EFP_RUN  = 3'b110
  } fcd_seq_type;
  // Job handed to the write state machine
  typedef enum logic [2:0] {
    FCD_OP_NONE  = 3'b000,
    FCD_OP_ERASE = 3'b001,
    FCD_OP_PROG  = 3'b010,
    FCD_OP_EFP   = 3'b011,
    FCD_OP_EDATA = 3'b100,
    FCD_OP_OTP   = 3'b101
  } fcd_op_type;
endpackage

// ---- verif/fcd_engine_model.sv ----
// Purpose: Write engine and array stand-in facing the decoder
// Assumes: Jobs arrive as one-cycle start pulses
// Notes:   Job time cut to BUSY_CYC+1 cycles of busy
`include "fcd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fcd_engine_model #(
  parameter int BUSY_CYC = 40
) (
  input  wire logic               i_clock,
  input  wire logic               i_srst,
  input  wire logic               i_start,
  input  wire fcd_pkg::fcd_op_type i_kind,
  input  wire logic [`FCD_AW-1:0] i_op_addr,
  input  wire logic               i_suspend,
  input  wire logic               i_resume,
  input  wire logic [`FCD_AW-1:0] i_addr,
  output logic                    o_busy,
  output logic [1:0]              o_part,
  output logic                    o_suspended,
  output logic                    o_ess,
  output logic                    o_pss,
  output logic [15:0]             o_array,
  output logic [7:0]              o_query
);
  import fcd_pkg::*;
  logic [8:0] left;
  logic       erasing;
  logic       long_job;
  // Contents differ per address so a wrong source shows
  assign o_array  = i_addr[15:0] ^ 16'h5a5a;
  assign o_query  = i_addr[7:0] ^ 8'hc3;
  assign o_ess    = o_suspended & erasing;
  assign o_pss    = o_suspended & ~erasing;
  assign long_job = i_kind == FCD_OP_ERASE || i_kind == FCD_OP_PROG || i_kind == FCD_OP_OTP;
  // Job timer; frozen while suspended, as the real engine would be
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_busy      <= 1'b0;
      o_part      <= 2'b00;
      o_suspended <= 1'b0;
      erasing     <= 1'b0;
      left        <= 9'h000;
    end else if (i_start && long_job) begin
      o_busy  <= 1'b1;
      o_part  <= i_op_addr[19:18];
      erasing <= i_kind == FCD_OP_ERASE;
      left    <= BUSY_CYC[8:0];
    end else if (i_suspend && o_busy) begin
      o_suspended <= 1'b1;
    end else if (i_resume) begin
      o_suspended <= 1'b0;
    end else if (o_busy && !o_suspended) begin
      o_busy <= left != 9'h000;
      left   <= left - 9'h001;
    end
  end
endmodule
`default_nettype wire

// ---- verif/flash_command_decoder_bench.sv ----
// Purpose: Self-checking bench of the flash command decoder
// Assumes: Strobes one cycle wide, driven just after the rising edge
// Notes:   Engine and array come from fcd_engine_model
`include "fcd_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module flash_command_decoder_bench;
  import fcd_pkg::*;
  localparam logic [19:0] P0 = 20'h00000, P1 = 20'h40000, P2 = 20'h80000, P3 = 20'hc0000;
  localparam logic [19:0] BK = 20'h48000;
  logic I_CLOCK = 1'b0, I_SRST = 1'b1, I_WE = 1'b0, I_RE = 1'b0, I_EFP_DONE = 1'b0;
  logic [19:0] I_ADDR = 20'h00000, O_OP_ADDR;
  logic [15:0] I_WDATA = 16'h0000, I_ARRAY_DATA, O_RDATA, O_OP_DATA;
  logic [7:0]  I_QUERY_DATA;
  logic [1:0]  I_WSM_PART;
  logic        I_WSM_BUSY, I_WSM_SUSPENDED, I_SR_ESS, I_SR_PSS, O_RVALID, O_OP_START, O_SUSPEND, O_RESUME;
  fcd_op_type  O_OP_KIND;
  logic [2:0]  ev;
  int          failures = 0, compares = 0, cycles = 0;
  // Clock and timeout
  always #2 I_CLOCK = ~I_CLOCK;
  always @(posedge I_CLOCK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  fcd_decoder fcd_decoder_i (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_WE(I_WE), .I_RE(I_RE), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_ARRAY_DATA(I_ARRAY_DATA), .I_QUERY_DATA(I_QUERY_DATA), .I_WSM_BUSY(I_WSM_BUSY),
    .I_WSM_PART(I_WSM_PART), .I_WSM_SUSPENDED(I_WSM_SUSPENDED), .I_WSM_ERASE_ERR(1'b0), .I_WSM_PROG_ERR(1'b0),
    .I_EFP_DONE(I_EFP_DONE), .I_SR_ESS(I_SR_ESS), .I_SR_VPPS(1'b0), .I_SR_PSS(I_SR_PSS), .I_SR_DPS(1'b0),
    .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_OP_START(O_OP_START), .O_OP_KIND(O_OP_KIND),
    .O_OP_ADDR(O_OP_ADDR), .O_OP_DATA(O_OP_DATA), .O_SUSPEND(O_SUSPEND), .O_RESUME(O_RESUME));
  fcd_engine_model #(.BUSY_CYC(40)) fcd_engine_model_i (.i_clock(I_CLOCK), .i_srst(I_SRST),
    .i_start(O_OP_START), .i_kind(O_OP_KIND), .i_op_addr(O_OP_ADDR), .i_suspend(O_SUSPEND),
    .i_resume(O_RESUME), .i_addr(I_ADDR), .o_busy(I_WSM_BUSY), .o_part(I_WSM_PART),
    .o_suspended(I_WSM_SUSPENDED), .o_ess(I_SR_ESS), .o_pss(I_SR_PSS), .o_array(I_ARRAY_DATA),
    .o_query(I_QUERY_DATA));
  // ---------------------------------------------
  // Bus cycles
  // ---------------------------------------------
  function automatic logic [15:0] arr(input logic [19:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction
  // One write; ev holds start, suspend, resume seen one cycle later
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge I_CLOCK);
    I_WE <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLOCK);
    I_WE <= 1'b0;
    #1;
    ev = {O_OP_START, O_SUSPEND, O_RESUME};
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    @(posedge I_CLOCK);
    I_RE <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLOCK);
    I_RE <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, O_RVALID)
    `CHK("rdata", e, O_RDATA)
  endtask
  task automatic job(input fcd_op_type k, input logic [19:0] a, input logic [15:0] d);
    `CHK("start", 3'b100, ev)
    `CHK("kind", k, O_OP_KIND)
    `CHK("op_addr", a, O_OP_ADDR)
    `CHK("op_data", d, O_OP_DATA)
  endtask
  task automatic wait_idle();
    // Engine only sees the start pulse one edge later; let busy rise first
    repeat (2) @(posedge I_CLOCK);
    for (int i = 0; i < 200 && I_WSM_BUSY !== 1'b0; i++) @(posedge I_CLOCK);
    `CHK("engine_idle", 1'b0, I_WSM_BUSY)
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_modes();
    for (int p = 0; p < 4; p++) rd({p[1:0], 18'h00107}, arr({p[1:0], 18'h00107}));
    wr(P1, 16'h0090);
    rd(P1 | 20'h00, `FCD_MAKER_CODE);
    rd(P1 | 20'h01, `FCD_PART_CODE);
    rd(P1 | 20'h05, `FCD_CFG_RESET);
    rd(P1 | 20'h02, {14'h0000, `FCD_LOCK_RESET});
    rd(P1 | 20'h80, `FCD_OTPL_RESET);
    rd(P1 | 20'h88, `FCD_OTP_RESET);
    wr(P1, 16'h0098);
    rd(P1 | 20'h1b, {8'h00, 8'h1b ^ 8'hc3});
    wr(P1, 16'h0077);
    rd(P1 | 20'h11, {8'h00, 8'h11 ^ 8'hc3});
    wr(P1, 16'h0070);
    rd(P1, 16'h0080);
    wr(P1, 16'h00ff);
    rd(P1 | 20'h33, arr(P1 | 20'h33));
  endtask
  task automatic t_erase();
    wr(P2 | 20'h08000, 16'h0020);
    rd(P2 | 20'h08000, 16'h0080);
    rd(P0 | 20'h00005, arr(P0 | 20'h00005));
    wr(P2 | 20'h08123, 16'h00d0);
    job(FCD_OP_ERASE, P2 | 20'h08123, 16'h00d0);
    wr(P2, 16'h00ff);
    rd(P2 | 20'h9, 16'hffff);
    wr(P2, 16'h0090);
    `CHK("no_job", 3'b000, ev)
    rd(P2, `FCD_MAKER_CODE);
    wait_idle();
    wr(P3, 16'h0020);
    wr(P3, 16'h0070);
    rd(P3, 16'h00b0);
    wr(P0, 16'h0050);
    rd(P3, 16'h0080);
  endtask
  task automatic t_jobs();
    logic [7:0] sc[2] = '{8'h40, 8'h10};
    foreach (sc[i]) begin
      wr(P0 | 20'h01234, {8'h00, sc[i]});
      wr(P0 | 20'h01234, 16'hbee0 | 16'(i));
      job(FCD_OP_PROG, P0 | 20'h01234, 16'hbee0 | 16'(i));
      wait_idle();
    end
    wr(P0 | 20'h81, 16'h00c0);
    wr(P0 | 20'h81, 16'h1234);
    job(FCD_OP_OTP, P0 | 20'h81, 16'h1234);
    wait_idle();
    wr(20'h00080, 16'h00c0);
    wr(20'h00080, `FCD_OTP_LOCK_VAL);
    job(FCD_OP_OTP, 20'h00080, `FCD_OTP_LOCK_VAL);
    wait_idle();
    wr(P0, 16'h0090);
    rd(P0 | 20'h81, 16'h1234);
    rd(P0 | 20'h80, `FCD_OTP_LOCK_VAL);
    wr(P0 | 20'h200, 16'h0030);
    wr(P0 | 20'h200, 16'h00d0);
    job(FCD_OP_EFP, P0 | 20'h200, 16'h00d0);
    wr(P0 | 20'h200, 16'h1111);
    job(FCD_OP_EDATA, P0 | 20'h200, 16'h1111);
    @(posedge I_CLOCK);
    I_EFP_DONE <= 1'b1;
    @(posedge I_CLOCK);
    I_EFP_DONE <= 1'b0;
    wr(P0, 16'h00ff);
    rd(P0 | 20'h201, arr(P0 | 20'h201));
  endtask
  task automatic t_lock_cfg();
    logic [7:0]  c2[4] = '{8'hd0, 8'h01, 8'h2f, 8'hd0};
    logic [15:0] ex[4] = '{16'h0000, 16'h0001, 16'h0003, 16'h0003};
    foreach (c2[i]) begin
      wr(BK, 16'h0060);
      wr(BK, {8'h00, c2[i]});
      `CHK("no_resume", 3'b000, ev)
      wr(BK, 16'h0090);
      rd(BK | 20'h02, ex[i]);
    end
    wr(P3 | 20'h01234, 16'h0060);
    wr(P3 | 20'h01234, 16'h0003);
    rd(P3 | 20'h7, arr(P3 | 20'h7));
    wr(P0, 16'h0090);
    rd(P0 | 20'h05, 16'h1234);
  endtask
  task automatic t_suspend();
    wr(P2 | 20'h44, 16'h0040);
    wr(P2 | 20'h44, 16'h0001);
    wr(P1 | 20'h7, 16'h00b0);
    `CHK("suspend", 3'b010, ev)
    wr(P2, 16'h00ff);
    rd(P2 | 20'h9, arr(P2 | 20'h9));
    wr(P3, 16'h00d0);
    `CHK("resume", 3'b001, ev)
    wait_idle();
  endtask
  // Mid-run reset: modes back to array, configuration back to its reset value
  task automatic t_reset();
    wr(P1, 16'h0070);
    @(posedge I_CLOCK);
    I_SRST <= 1'b1;
    repeat (2) @(posedge I_CLOCK);
    I_SRST <= 1'b0;
    rd(P1 | 20'h5, arr(P1 | 20'h5));
    wr(P1, 16'h0090);
    rd(P1 | 20'h05, `FCD_CFG_RESET);
  endtask
  task automatic close_out();
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge I_CLOCK);
    I_SRST <= 1'b0;
    t_modes();
    t_erase();
    t_jobs();
    t_lock_cfg();
    t_suspend();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
